// File: bcr_chan.sv
// One regulator channel: soft-start timer, target code, ramp and comparator blanking
`timescale 1ns/1ns
`default_nettype none
`include "bcr_defines.svh"

module bcr_chan #(
  parameter int unsigned W        = 8,
  parameter bit          RAMP     = 1'b0,
  parameter int unsigned SS_CYC   = 1,
  parameter int unsigned STEP_CYC = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         srst,
  // Control
  input  wire logic         en,
  input  wire logic         fall_ramp_en,
  input  wire logic [W-1:0] code,
  // Results
  output logic [W-1:0]      target,
  output bcr_pkg::bcr_phase_t phase,
  output logic              uv_blank,
  output logic              ov_blank
);
  import bcr_pkg::*;

  localparam int CW = `BCR_CNT_W;
  localparam logic [CW-1:0] SS_LAST   = CW'(SS_CYC - 1);
  localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYC - 1);

  typedef struct packed {
    bcr_phase_t    ph;
    logic          fall;
    logic [CW-1:0] cnt;
    logic [W-1:0]  tgt;
  } bcr_chan_state_t;

  bcr_chan_state_t q;
  bcr_chan_state_t d;

  always_comb begin
    d = q;
    case (q.ph)
      bcr_ph_off: begin
        d.tgt = code;
        d.cnt = '0;
        if (en) d.ph = bcr_ph_soft;
      end
      bcr_ph_soft: begin
        d.tgt = code;
        d.cnt = q.cnt + 1'b1;
        if (!en) d.ph = bcr_ph_off;
        else if (q.cnt == SS_LAST) d.ph = bcr_ph_steady;
      end
      bcr_ph_steady: begin
        d.cnt = '0;
        if (!en) d.ph = bcr_ph_off;
        else if (code != q.tgt) begin
          if (RAMP && code > q.tgt) begin
            d.ph   = bcr_ph_ramp;
            d.fall = 1'b0;
          end else if (RAMP && fall_ramp_en) begin
            d.ph   = bcr_ph_ramp;
            d.fall = 1'b1;
          end else d.tgt = code;
        end
      end
      bcr_ph_ramp: begin
        if (!en) d.ph = bcr_ph_off;
        else if (q.cnt == STEP_LAST) begin
          d.cnt = '0;
          if (code == q.tgt) d.ph = bcr_ph_steady;
          else if (code > q.tgt) begin
            d.tgt  = q.tgt + 1'b1;
            d.fall = 1'b0;
          end else begin
            d.tgt  = q.tgt - 1'b1;
            d.fall = 1'b1;
          end
        end else d.cnt = q.cnt + 1'b1;
      end
      default: d.ph = bcr_ph_off;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) q <= '0;
    else q <= d;
  end

  // Off and soft-start blank both comparators; a ramp blanks the one its direction trips
  assign target   = q.tgt;
  assign phase    = q.ph;
  assign uv_blank = (q.ph == bcr_ph_off) || (q.ph == bcr_ph_soft) || (q.ph == bcr_ph_ramp && !q.fall);
  assign ov_blank = (q.ph == bcr_ph_off) || (q.ph == bcr_ph_soft) || (q.ph == bcr_ph_ramp && q.fall);

endmodule : bcr_chan
`default_nettype wire

// File: bcr_defines.svh
// Offsets, field positions, codes and timing counts of the buck regulator control block
`ifndef BCR_DEFINES_SVH
`define BCR_DEFINES_SVH

// Voltage code widths and steps
`define BCR_VOUT12_W      8
`define BCR_VOUT3_W       7
`define BCR_STEP12_UV     6250
`define BCR_MIN12_MV      600
`define BCR_MAX12_MV      2194
`define BCR_STEP3_MV      10
`define BCR_MIN3_MV       260
`define BCR_MAX3_MV       1520

// Operating mode codes
`define BCR_OPMD_OFF      2'h0
`define BCR_OPMD_SLEEP    2'h1
`define BCR_OPMD_LOWPWR   2'h2
`define BCR_OPMD_NORMAL   2'h3

// Sequencer configuration fields
`define BCR_SEQ_PU_BIT    7
`define BCR_SEQ_PD_BIT    6
`define BCR_SEQ_MST_LSB   4
`define BCR_SEQ_MST_W     2
`define BCR_SEQ_SLOT_LSB  0
`define BCR_SEQ_SLOT_W    3
`define BCR_SEQ_CFG_W     8

// Timing
`define BCR_CLK_NS        4
`define BCR_SS_TIME_NS    200000
`define BCR_SS_CYC        ((`BCR_SS_TIME_NS + `BCR_CLK_NS - 1) / `BCR_CLK_NS)
`define BCR_STEP_TIME_NS  4000
`define BCR_STEP_CYC      ((`BCR_STEP_TIME_NS + `BCR_CLK_NS - 1) / `BCR_CLK_NS)
`define BCR_CNT_W         17

`endif

// File: bcr_pkg.sv
// Types shared by the buck regulator control modules
package bcr_pkg;

  typedef enum logic [1:0] {
    bcr_ph_off,
    bcr_ph_soft,
    bcr_ph_ramp,
    bcr_ph_steady
  } bcr_phase_t;

endpackage : bcr_pkg

// File: bcr_top.sv
// Control and fault monitoring for three step-down regulators
// How it works
// - Regulators one and two take an 8-bit code, 6.25 mV per step.
// - Regulator three takes a 7-bit code, 10 mV per step.
// - Undervoltage sets that regulator's flag in the shared flag vector.
// - Overvoltage sets that regulator's overvoltage flag.
// - An event requests power-down only when its mask bit is clear.
// - Flags set on events whether masked or not.
// - Regulators one and two blank undervoltage until soft-start ends.
// - Regulators one and two blank overvoltage until soft-start ends.
// - Code changes on regulators one and two jump straight, no ramp, no blanking.
// - Regulator three blanks undervoltage until soft-start completes.
// - Regulator three blanks undervoltage during a rising ramp.
// - Falling ramp blanks overvoltage; from steady a drop ramps only when enabled, otherwise code drops at once.
// - Live status bits show present conditions, separate from latched flags.
// - Mode 00 without sequencer control turns the regulator off.
// - Sequencer config selects power-up, power-down joining, master and slot.
// - Mode 01 enters low power while the device sleeps.
// - Mode 10 forces low power regardless of sleep.
// - Discharge path connects while disabled, disconnects while enabled.
// - Each regulator discharges while disabled only with its disable bit zero.
// - Mode decode per table; sequencer enable gates assigned regulators.
`timescale 1ns/1ns
`default_nettype none
`include "bcr_defines.svh"

module bcr_top #(
  parameter int unsigned SS_CYC = `BCR_SS_CYC
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           srst,
  // Voltage codes
  input  wire logic [`BCR_VOUT12_W-1:0]       reg_vout_code_1,
  input  wire logic [`BCR_VOUT12_W-1:0]       reg_vout_code_2,
  input  wire logic [`BCR_VOUT3_W-1:0]        third_reg_vout_code,
  input  wire logic                           falling_ramp_enable,
  // Mode control, two bits per regulator, regulator three highest
  input  wire logic [5:0]                     reg_operating_mode,
  input  wire logic [2:0]                     sequencer_assign_bit,
  input  wire logic [2:0]                     sequencer_enable_signal,
  input  wire logic                           sleep_state_flag,
  input  wire logic [2:0]                     reg_discharge_disable,
  // Sequencer configuration
  input  wire logic [`BCR_SEQ_CFG_W-1:0]      reg_sequencer_config_1,
  input  wire logic [`BCR_SEQ_CFG_W-1:0]      reg_sequencer_config_2,
  input  wire logic [`BCR_SEQ_CFG_W-1:0]      third_reg_sequencer_config,
  // Masks and flag clears
  input  wire logic [2:0]                     reg_undervolt_mask,
  input  wire logic [2:0]                     reg_overvolt_mask,
  input  wire logic [2:0]                     undervolt_flag_clear,
  input  wire logic [2:0]                     overvolt_flag_clear,
  // Comparator pins
  input  wire logic [2:0]                     undervolt_cmp,
  input  wire logic [2:0]                     overvolt_cmp,
  // Regulator drive
  output logic [`BCR_VOUT12_W-1:0]            vout_target_1,
  output logic [`BCR_VOUT12_W-1:0]            vout_target_2,
  output logic [`BCR_VOUT3_W-1:0]             third_vout_target,
  output logic [2:0]                          reg_enable,
  output logic [2:0]                          low_power_state,
  output logic [2:0]                          discharge_on,
  // Flags and status
  output logic [2:0]                          reg_undervolt_flag,
  output logic [2:0]                          reg_overvolt_flag,
  output logic [2:0]                          undervolt_status,
  output logic [2:0]                          overvolt_status,
  output logic                                power_down_req,
  // Sequencer membership
  output logic [2:0]                          seq_join_up,
  output logic [2:0]                          seq_join_down,
  output logic [3*`BCR_SEQ_MST_W-1:0]         seq_master,
  output logic [3*`BCR_SEQ_SLOT_W-1:0]        seq_slot
);
  import bcr_pkg::*;

  localparam int VW = `BCR_VOUT12_W;
  localparam int TW = `BCR_VOUT3_W;
  localparam int MW = `BCR_SEQ_MST_W;
  localparam int SW = `BCR_SEQ_SLOT_W;

  typedef struct packed {
    logic [2:0]    uv_s1;
    logic [2:0]    uv_s2;
    logic [2:0]    ov_s1;
    logic [2:0]    ov_s2;
    logic [2:0]    en;
    logic [2:0]    lp;
    logic [2:0]    dis;
    logic [2:0]    uv_flag;
    logic [2:0]    ov_flag;
    logic [2:0]    uv_stat;
    logic [2:0]    ov_stat;
    logic [5:0]    trig;
    logic          pd;
    logic [VW-1:0] tgt1;
    logic [VW-1:0] tgt2;
    logic [TW-1:0] tgt3;
    logic [2:0]    pu;
    logic [2:0]    pdn;
    logic [3*MW-1:0] mst;
    logic [3*SW-1:0] slot;
  } bcr_top_state_t;

  bcr_top_state_t q;
  bcr_top_state_t d;

  logic [VW-1:0] tgt1_w;
  logic [VW-1:0] tgt2_w;
  logic [TW-1:0] tgt3_w;
  logic [2:0]    uv_blank;
  logic [2:0]    ov_blank;

  // Regulators one and two jump straight to a new code
  bcr_chan #(
    .W        (VW),
    .RAMP     (1'b0),
    .SS_CYC   (SS_CYC),
    .STEP_CYC (`BCR_STEP_CYC)
  ) u_chan1 (
    .clock        (clock),
    .srst         (srst),
    .en           (q.en[0]),
    .fall_ramp_en (1'b0),
    .code         (reg_vout_code_1),
    .target       (tgt1_w),
    .phase        (),
    .uv_blank     (uv_blank[0]),
    .ov_blank     (ov_blank[0])
  );

  bcr_chan #(
    .W        (VW),
    .RAMP     (1'b0),
    .SS_CYC   (SS_CYC),
    .STEP_CYC (`BCR_STEP_CYC)
  ) u_chan2 (
    .clock        (clock),
    .srst         (srst),
    .en           (q.en[1]),
    .fall_ramp_en (1'b0),
    .code         (reg_vout_code_2),
    .target       (tgt2_w),
    .phase        (),
    .uv_blank     (uv_blank[1]),
    .ov_blank     (ov_blank[1])
  );

  // Regulator three walks up to a new code one step at a time, and down only with falling ramp enabled or while already ramping
  bcr_chan #(
    .W        (TW),
    .RAMP     (1'b1),
    .SS_CYC   (SS_CYC),
    .STEP_CYC (`BCR_STEP_CYC)
  ) u_chan3 (
    .clock        (clock),
    .srst         (srst),
    .en           (q.en[2]),
    .fall_ramp_en (falling_ramp_enable),
    .code         (third_reg_vout_code),
    .target       (tgt3_w),
    .phase        (),
    .uv_blank     (uv_blank[2]),
    .ov_blank     (ov_blank[2])
  );

  logic [2:0] uv_cond;
  logic [2:0] ov_cond;
  logic [5:0] trig;
  logic [`BCR_SEQ_CFG_W-1:0] cfg [3];

  assign cfg[0] = reg_sequencer_config_1;
  assign cfg[1] = reg_sequencer_config_2;
  assign cfg[2] = third_reg_sequencer_config;

  // Blanked comparators give the present condition
  assign uv_cond = q.uv_s2 & ~uv_blank;
  assign ov_cond = q.ov_s2 & ~ov_blank;
  assign trig    = {ov_cond & ~reg_overvolt_mask, uv_cond & ~reg_undervolt_mask};

  always_comb begin
    logic [1:0] md;
    md = 2'h0;
    d  = q;

    // Comparator pins are asynchronous to the clock
    d.uv_s1 = undervolt_cmp;
    d.uv_s2 = q.uv_s1;
    d.ov_s1 = overvolt_cmp;
    d.ov_s2 = q.ov_s1;

    for (int i = 0; i < 3; i++) begin
      md = reg_operating_mode[2*i +: 2];
      if (sequencer_assign_bit[i] && !sequencer_enable_signal[i]) begin
        d.en[i] = 1'b0;
        d.lp[i] = 1'b0;
      end else begin
        case (md)
          `BCR_OPMD_OFF: begin
            d.en[i] = 1'b0;
            d.lp[i] = 1'b0;
          end
          `BCR_OPMD_SLEEP: begin
            d.en[i] = 1'b1;
            d.lp[i] = sleep_state_flag;
          end
          `BCR_OPMD_LOWPWR: begin
            d.en[i] = 1'b1;
            d.lp[i] = 1'b1;
          end
          default: begin
            d.en[i] = 1'b1;
            d.lp[i] = 1'b0;
          end
        endcase
      end
      // Discharge follows the registered enable, so it stays on for one cycle after enable rises
      d.dis[i] = !q.en[i] && !reg_discharge_disable[i];

      d.pu[i]             = cfg[i][`BCR_SEQ_PU_BIT];
      d.pdn[i]            = cfg[i][`BCR_SEQ_PD_BIT];
      d.mst[MW*i +: MW]   = cfg[i][`BCR_SEQ_MST_LSB +: MW];
      d.slot[SW*i +: SW]  = cfg[i][`BCR_SEQ_SLOT_LSB +: SW];
    end

    // Set wins over a clear arriving in the same cycle
    d.uv_flag = (q.uv_flag & ~undervolt_flag_clear) | uv_cond;
    d.ov_flag = (q.ov_flag & ~overvolt_flag_clear) | ov_cond;
    d.uv_stat = uv_cond;
    d.ov_stat = ov_cond;

    // One pulse per cycle in which an unmasked event newly appears
    d.trig = trig;
    d.pd   = |(trig & ~q.trig);

    d.tgt1 = tgt1_w;
    d.tgt2 = tgt2_w;
    d.tgt3 = tgt3_w;
  end

  always_ff @(posedge clock) begin
    if (srst) q <= '0;
    else q <= d;
  end

  assign vout_target_1      = q.tgt1;
  assign vout_target_2      = q.tgt2;
  assign third_vout_target  = q.tgt3;
  assign reg_enable         = q.en;
  assign low_power_state    = q.lp;
  assign discharge_on       = q.dis;
  assign reg_undervolt_flag = q.uv_flag;
  assign reg_overvolt_flag  = q.ov_flag;
  assign undervolt_status   = q.uv_stat;
  assign overvolt_status    = q.ov_stat;
  assign power_down_req     = q.pd;
  assign seq_join_up        = q.pu;
  assign seq_join_down      = q.pdn;
  assign seq_master         = q.mst;
  assign seq_slot           = q.slot;

endmodule : bcr_top
`default_nettype wire

// File: bcr_top_asserts.sv
// Assertion checker bound to the buck regulator control top
`timescale 1ns/1ns
`default_nettype none
module bcr_top_asserts #(
  parameter int unsigned SS_CYC = 8
) (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [7:0] reg_vout_code_1,
  input wire logic [5:0] reg_operating_mode,
  input wire logic [2:0] sequencer_assign_bit,
  input wire logic [2:0] reg_discharge_disable,
  input wire logic [2:0] reg_undervolt_mask,
  input wire logic [2:0] undervolt_flag_clear,
  input wire logic [7:0] vout_target_1,
  input wire logic [2:0] reg_enable,
  input wire logic [2:0] discharge_on,
  input wire logic [2:0] reg_undervolt_flag,
  input wire logic [2:0] reg_overvolt_flag,
  input wire logic [2:0] undervolt_status,
  input wire logic [2:0] overvolt_status,
  input wire logic       power_down_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_uv_flag_set: assert property ((undervolt_status & ~reg_undervolt_flag) == 3'h0)
    else $error("uv flag missing");
  chk_ov_flag_set: assert property ((overvolt_status & ~reg_overvolt_flag) == 3'h0)
    else $error("ov flag missing");
  chk_flag_held: assert property (reg_undervolt_flag[0] && !undervolt_flag_clear[0] |=> reg_undervolt_flag[0])
    else $error("flag lost");
  chk_mode_off: assert property (reg_operating_mode[1:0] == 2'h0 && !sequencer_assign_bit[0] |=> !reg_enable[0])
    else $error("off mode enabled");
  chk_dis_on: assert property (!reg_enable[0] && !reg_discharge_disable[0] |=> discharge_on[0])
    else $error("discharge missing");
  chk_dis_off: assert property (reg_enable[2] |=> !discharge_on[2])
    else $error("discharge while on");
  chk_pd_start: assert property ($rose(undervolt_status[0]) && !$past(reg_undervolt_mask[0]) |-> power_down_req)
    else $error("no power down");
  chk_ss_blank: assert property ($rose(reg_enable[1]) |-> (undervolt_status[1] == 1'b0 && overvolt_status[1] == 1'b0) [*8])
    else $error("soft start not blanked");
  chk_target_jump: assert property (1'b1 |-> ##2 vout_target_1 == $past(reg_vout_code_1, 2))
    else $error("target lag");

  // Cycles since regulator two was enabled, saturating
  logic [16:0] ss_age_q;
  always_ff @(posedge clock) begin
    if (srst || !reg_enable[1]) begin
      ss_age_q <= 17'h0_0000;
    end else if (ss_age_q != 17'h1_FFFF) begin
      ss_age_q <= ss_age_q + 17'h0_0001;
    end
  end

  chk_ss_length: assert property (ss_age_q != 17'h0_0000 && ss_age_q <= SS_CYC + 1 |->
    !undervolt_status[1] && !overvolt_status[1])
    else $error("soft start too short");

  cov_pd: cover property (power_down_req);
  cov_en: cover property ($rose(reg_enable[1]));
  cov_latched: cover property (reg_undervolt_flag[0] && !undervolt_status[0]);
endmodule : bcr_top_asserts

bind bcr_top bcr_top_asserts #(.SS_CYC(SS_CYC)) i_chk (
  .clock, .srst, .reg_vout_code_1, .reg_operating_mode, .sequencer_assign_bit, .reg_discharge_disable,
  .reg_undervolt_mask, .undervolt_flag_clear, .vout_target_1, .reg_enable, .discharge_on, .reg_undervolt_flag,
  .reg_overvolt_flag, .undervolt_status, .overvolt_status, .power_down_req
);
`default_nettype wire

// File: bcr_top_tb.sv
// Self-checking testbench for the buck regulator control top
`timescale 1ns/1ns
`default_nettype none
module bcr_top_tb;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] reg_vout_code_1, reg_vout_code_2, reg_sequencer_config_1, reg_sequencer_config_2;
  logic [7:0] third_reg_sequencer_config, vout_target_1, vout_target_2;
  logic [6:0] third_reg_vout_code, third_vout_target;
  logic [5:0] reg_operating_mode, seq_master;
  logic [8:0] seq_slot;
  logic       falling_ramp_enable, sleep_state_flag, power_down_req;
  logic [2:0] sequencer_assign_bit, sequencer_enable_signal, reg_discharge_disable, reg_undervolt_mask;
  logic [2:0] reg_overvolt_mask, undervolt_flag_clear, overvolt_flag_clear, undervolt_cmp, overvolt_cmp;
  logic [2:0] reg_enable, low_power_state, discharge_on, reg_undervolt_flag, reg_overvolt_flag;
  logic [2:0] undervolt_status, overvolt_status, seq_join_up, seq_join_down;
  int         err_total = 0;
  int         samples_checked = 0;

  bcr_top #(.SS_CYC(8)) i_dut (
    .clock, .srst, .reg_vout_code_1, .reg_vout_code_2, .third_reg_vout_code, .falling_ramp_enable,
    .reg_operating_mode, .sequencer_assign_bit, .sequencer_enable_signal, .sleep_state_flag,
    .reg_discharge_disable, .reg_sequencer_config_1, .reg_sequencer_config_2, .third_reg_sequencer_config,
    .reg_undervolt_mask, .reg_overvolt_mask, .undervolt_flag_clear, .overvolt_flag_clear, .undervolt_cmp,
    .overvolt_cmp, .vout_target_1, .vout_target_2, .third_vout_target, .reg_enable, .low_power_state,
    .discharge_on, .reg_undervolt_flag, .reg_overvolt_flag, .undervolt_status, .overvolt_status,
    .power_down_req, .seq_join_up, .seq_join_down, .seq_master, .seq_slot
  );

  always #2 clock = ~clock;

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic sc_mode;
    for (int m = 7; m >= 0; m--) begin
      reg_operating_mode[1:0] = m[1:0];
      sleep_state_flag = m[2];
      tick(1);
      check(reg_enable[0], m[1:0] != 2'h0);
      check(low_power_state[0], m[1:0] == 2'h2 || (m[1:0] == 2'h1 && m[2]));
    end
    // Assignment only toggled while the regulator is off
    sequencer_assign_bit[0] = 1'b1;
    reg_operating_mode[1:0] = 2'h3;
    tick(1);
    check(reg_enable[0], 1'b0);
    sequencer_enable_signal[0] = 1'b1;
    tick(1);
    check(reg_enable[0], 1'b1);
    reg_operating_mode[1:0] = 2'h0;
    tick(1);
    check(reg_enable[0], 1'b0);
    sequencer_enable_signal[0] = 1'b0;
    sequencer_assign_bit[0] = 1'b0;
    reg_sequencer_config_1 = 8'hB5;
    third_reg_sequencer_config = 8'h4A;
    tick(1);
    check({seq_join_up, seq_join_down}, 6'h0C);
    check({seq_master, seq_slot}, 15'h0685);
  endtask : sc_mode

  task automatic sc_discharge;
    reg_discharge_disable = 3'h4;
    tick(2);
    check(discharge_on, 3'h3);
    reg_operating_mode = 6'h33;
    tick(2);
    check({reg_enable, discharge_on}, 6'h2A);
    tick(20);
  endtask : sc_discharge

  task automatic sc_fault;
    undervolt_cmp[0] = 1'b1;
    tick(3);
    check({undervolt_status[0], reg_undervolt_flag[0], power_down_req}, 3'h7);
    undervolt_cmp[0] = 1'b0;
    tick(1);
    check(power_down_req, 1'b0);
    tick(3);
    check({undervolt_status[0], reg_undervolt_flag[0]}, 2'h1);
    undervolt_flag_clear[0] = 1'b1;
    tick(1);
    undervolt_flag_clear[0] = 1'b0;
    check(reg_undervolt_flag[0], 1'b0);
    reg_overvolt_mask[2] = 1'b1;
    overvolt_cmp[2] = 1'b1;
    tick(3);
    check({overvolt_status[2], reg_overvolt_flag[2], power_down_req}, 3'h6);
    overvolt_cmp[2] = 1'b0;
    tick(4);
    reg_overvolt_mask[2] = 1'b0;
  endtask : sc_fault

  task automatic sc_blank;
    {undervolt_cmp[1], overvolt_cmp[1]} = 2'h3;
    reg_operating_mode[3:2] = 2'h3;
    tick(8);
    check({undervolt_status[1], overvolt_status[1]}, 2'h0);
    tick(20);
    check({undervolt_status[1], overvolt_status[1]}, 2'h3);
    {undervolt_cmp[1], overvolt_cmp[1]} = 2'h0;
    reg_operating_mode[3:2] = 2'h0;
    {reg_undervolt_mask[0], reg_overvolt_mask[0]} = 2'h3;
    reg_vout_code_1 = 8'h53;
    reg_vout_code_2 = 8'hFF;
    tick(2);
    check({vout_target_1, vout_target_2}, 16'h53FF);
  endtask : sc_blank

  task automatic sc_ramp;
    undervolt_cmp[2] = 1'b1;
    third_reg_vout_code = 7'h02;
    tick(500);
    check(undervolt_status[2], 1'b0);
    tick(3200);
    check({third_vout_target, undervolt_status[2]}, 8'h05);
    undervolt_cmp[2] = 1'b0;
    falling_ramp_enable = 1'b1;
    overvolt_cmp[2] = 1'b1;
    third_reg_vout_code = 7'h00;
    tick(500);
    check(overvolt_status[2], 1'b0);
    tick(3200);
    check({third_vout_target, overvolt_status[2]}, 8'h01);
    overvolt_cmp[2] = 1'b0;
    third_reg_vout_code = 7'h01;
    tick(3200);
    falling_ramp_enable = 1'b0;
    overvolt_cmp[2] = 1'b1;
    third_reg_vout_code = 7'h00;
    tick(3);
    check({overvolt_status[2], power_down_req}, 2'h3);
    tick(1);
    check(third_vout_target, 7'h00);
  endtask : sc_ramp

  initial begin
    {reg_vout_code_1, reg_vout_code_2, third_reg_vout_code, falling_ramp_enable, reg_operating_mode} = '0;
    {sequencer_assign_bit, sequencer_enable_signal, sleep_state_flag, reg_discharge_disable} = '0;
    {reg_sequencer_config_1, reg_sequencer_config_2, third_reg_sequencer_config} = '0;
    {reg_undervolt_mask, reg_overvolt_mask, undervolt_flag_clear, overvolt_flag_clear} = '0;
    {undervolt_cmp, overvolt_cmp} = '0;
    tick(2);
    srst = 1'b0;
    sc_mode();
    sc_discharge();
    sc_fault();
    sc_blank();
    sc_ramp();
    complete_run();
  end

  initial begin
    #120000;
    err_total++;
    complete_run();
  end
endmodule : bcr_top_tb
`default_nettype wire
